// >>> calo_pkg.sv
// Shared constants, opcodes, state counts and enumerations of the arithmetic/logic datapath
package calo_pkg;
	// Instruction prefix bytes
	localparam logic [7:0] PFX_PAIR = 8'h74;
	localparam logic [7:0] PFX_EXT = 8'h48;
	// Upper six bits of second byte
	localparam logic [5:0] OPC_ANDNZ = 6'h33;
	localparam logic [5:0] OPC_ANDZ = 6'h37;
	localparam logic [5:0] OPC_MUL = 6'h0b;
	localparam logic [5:0] OPC_DIV = 6'h0f;
	// Upper six bits of single-byte register ops
	localparam logic [5:0] OPC_INR = 6'h10;
	localparam logic [5:0] OPC_DCR = 6'h14;
	// Whole opcode bytes
	localparam logic [7:0] OPC_PAGE_INCREMENT = 8'h20;
	localparam logic [7:0] OPC_PAGE_DECREMENT = 8'h30;
	localparam logic [7:0] OPC_INXEA = 8'ha8;
	localparam logic [7:0] OPC_DCXEA = 8'ha9;
	localparam logic [7:0] OPC_DAA = 8'h61;
	localparam logic [7:0] OPC_STC = 8'h2b;
	localparam logic [7:0] OPC_CLC = 8'h2a;
	localparam logic [7:0] OPC_ACCUMULATOR_TWOS_COMPLEMENT = 8'h3a;
	localparam logic [7:0] OPC_RLD = 8'h38;
	localparam logic [7:0] OPC_RRD = 8'h39;
	// Low nibble of pair step ops, top two bits zero
	localparam logic [3:0] OPC_INX = 4'h2;
	localparam logic [3:0] OPC_DCX = 4'h3;
	// Execution lengths in states, one state per clock
	localparam logic [5:0] NS_AND = 6'h0b;
	localparam logic [5:0] NS_MUL = 6'h20;
	localparam logic [5:0] NS_DIV = 6'h3b;
	localparam logic [5:0] NS_BYTE = 6'h04;
	localparam logic [5:0] NS_PAGE = 6'h10;
	localparam logic [5:0] NS_PAIR = 6'h07;
	localparam logic [5:0] NS_EXT = 6'h08;
	localparam logic [5:0] NS_ROT = 6'h11;
	// Register byte offsets
	localparam logic [7:0] OFF_BYTES = 8'h00;
	localparam logic [7:0] OFF_EA = 8'h04;
	localparam logic [7:0] OFF_BC = 8'h08;
	localparam logic [7:0] OFF_DE = 8'h0c;
	localparam logic [7:0] OFF_HL = 8'h10;
	localparam logic [7:0] OFF_SP = 8'h14;
	localparam logic [7:0] OFF_FLAGS = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	// Reset value of EA; every other register resets to zero
	localparam logic [15:0] RST_REG = 16'h0000;
	// AXI responses
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	// Operation classes
	typedef enum logic [4:0] {
		OP_NONE = 5'b00000, OP_ANDNZ = 5'b00001, OP_ANDZ = 5'b00010, OP_MUL = 5'b00011,
		OP_DIV = 5'b00100, OP_INR = 5'b00101, OP_DCR = 5'b00110, OP_PAGE_INCREMENT = 5'b00111,
		OP_PAGE_DECREMENT = 5'b01000, OP_INX = 5'b01001, OP_DCX = 5'b01010, OP_INXEA = 5'b01011,
		OP_DCXEA = 5'b01100, OP_DAA = 5'b01101, OP_STC = 5'b01110, OP_CLC = 5'b01111,
		OP_ACCUMULATOR_TWOS_COMPLEMENT = 5'b10000, OP_RLD = 5'b10001, OP_RRD = 5'b10010
	} calo_op_e;
	// Sequencer states
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} calo_st_e;
	// Memory access phases
	typedef enum logic [1:0] {MP_RD = 2'b00, MP_WR = 2'b01, MP_DN = 2'b10} calo_mp_e;
endpackage

// >>> calo_datapath.sv
// Arithmetic/logic execution datapath with its architectural registers and AXI4-Lite access
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - AND-test EA with pair, skip if nonzero
// - AND-test EA with pair, skip if zero
// - Zero-test is prefix byte plus pattern, pair
// - Pair field one to three picks BC, DE, HL
// - Unsigned A times register into EA, 32 states
// - Multiply and divide share prefix, low bits register
// - EA divided by register, remainder back, 59
// - Zero divisor gives all ones, old low byte
// - Byte field one to three picks A, B, C
// - Byte increment, four states, skip on carry
// - Byte decrement, four states, skip on borrow
// - Step ops set Z, HC, skip; keep carry
// - Page increment at V and offset, 16 states
// - Page decrement, 16 states, skip on borrow
// - Pair step on SP, BC, DE, HL, 7 states
// - Wide accumulator step, 7 states, no skip
// - Decimal adjust adds 00, 06, 60, 66
// - Carry set or clear, eight states
// - Accumulator negate, eight states
// - Left digit rotate through memory nibbles
// - Right digit rotate, seventeen states
// - Rotates use HL, keep A high nibble
module calo_datapath #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic op_valid,
	input wire logic [7:0] op_byte0,
	input wire logic [7:0] op_byte1,
	output logic op_ready,
	output logic op_done,
	output logic pass_over,
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack
);
	// Whole state of the block
	typedef struct packed {
		calo_pkg::calo_st_e st;
		calo_pkg::calo_op_e op;
		logic [1:0] sel;
		logic [5:0] cnt;
		calo_pkg::calo_mp_e mph;
		logic [7:0] mdat;
		logic [7:0] a, b, c, v;
		logic [15:0] ea, bc, de, hl, sp;
		logic z, sk, hc, l1, l0, cy;
		logic rdy, done, mreq, mwe;
		logic [15:0] maddr;
		logic [7:0] mwd;
		logic awr, wr, awg, wg, bv, arr, rv;
		logic [ADDR_W-1:0] awa;
		logic [31:0] wd, rd;
		logic [3:0] ws;
		logic [1:0] br, rr;
	} calo_state_s;

	calo_state_s s_r, s_nxt;
	logic [ADDR_W-1:0] wal, ral; // Word-aligned bus addresses
	logic acc; // Instruction taken this cycle
	calo_pkg::calo_op_e dop; // Decoded class of offered bytes
	logic [1:0] dsel; // Decoded selector
	logic [7:0] bval, bres, xin, xres, ea_lo;
	logic [15:0] pval, pres, and16, rem16;
	logic [31:0] wtmp;
	logic [8:0] sum9;
	logic bwr, pwr, lo_adj, hi_adj;

	// Merge written bytes into an old word by strobe
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Classify an instruction from its two bytes
	function automatic calo_pkg::calo_op_e dec(input logic [7:0] b0, input logic [7:0] b1);
		calo_pkg::calo_op_e o;
		o = calo_pkg::OP_NONE;
		if (b0 == calo_pkg::PFX_PAIR && b1[1:0] != 2'b00) begin
			if (b1[7:2] == calo_pkg::OPC_ANDNZ) o = calo_pkg::OP_ANDNZ;
			if (b1[7:2] == calo_pkg::OPC_ANDZ) o = calo_pkg::OP_ANDZ;
		end else if (b0 == calo_pkg::PFX_EXT) begin
			if (b1[7:2] == calo_pkg::OPC_MUL && b1[1:0] != 2'b00) o = calo_pkg::OP_MUL;
			if (b1[7:2] == calo_pkg::OPC_DIV && b1[1:0] != 2'b00) o = calo_pkg::OP_DIV;
			if (b1 == calo_pkg::OPC_STC) o = calo_pkg::OP_STC;
			if (b1 == calo_pkg::OPC_CLC) o = calo_pkg::OP_CLC;
			if (b1 == calo_pkg::OPC_ACCUMULATOR_TWOS_COMPLEMENT) o = calo_pkg::OP_ACCUMULATOR_TWOS_COMPLEMENT;
			if (b1 == calo_pkg::OPC_RLD) o = calo_pkg::OP_RLD;
			if (b1 == calo_pkg::OPC_RRD) o = calo_pkg::OP_RRD;
		end else begin
			if (b0[7:2] == calo_pkg::OPC_INR && b0[1:0] != 2'b00) o = calo_pkg::OP_INR;
			if (b0[7:2] == calo_pkg::OPC_DCR && b0[1:0] != 2'b00) o = calo_pkg::OP_DCR;
			if (b0 == calo_pkg::OPC_PAGE_INCREMENT) o = calo_pkg::OP_PAGE_INCREMENT;
			if (b0 == calo_pkg::OPC_PAGE_DECREMENT) o = calo_pkg::OP_PAGE_DECREMENT;
			if (b0 == calo_pkg::OPC_INXEA) o = calo_pkg::OP_INXEA;
			if (b0 == calo_pkg::OPC_DCXEA) o = calo_pkg::OP_DCXEA;
			if (b0 == calo_pkg::OPC_DAA) o = calo_pkg::OP_DAA;
			if (b0[7:6] == 2'b00 && b0[3:0] == calo_pkg::OPC_INX) o = calo_pkg::OP_INX;
			if (b0[7:6] == 2'b00 && b0[3:0] == calo_pkg::OPC_DCX) o = calo_pkg::OP_DCX;
		end
		return o;
	endfunction

	// Number of states each class takes
	function automatic logic [5:0] nstates(input calo_pkg::calo_op_e o);
		case (o)
			calo_pkg::OP_ANDNZ, calo_pkg::OP_ANDZ: return calo_pkg::NS_AND;
			calo_pkg::OP_MUL: return calo_pkg::NS_MUL;
			calo_pkg::OP_DIV: return calo_pkg::NS_DIV;
			calo_pkg::OP_PAGE_INCREMENT, calo_pkg::OP_PAGE_DECREMENT: return calo_pkg::NS_PAGE;
			calo_pkg::OP_INX, calo_pkg::OP_DCX, calo_pkg::OP_INXEA, calo_pkg::OP_DCXEA: return calo_pkg::NS_PAIR;
			calo_pkg::OP_STC, calo_pkg::OP_CLC, calo_pkg::OP_ACCUMULATOR_TWOS_COMPLEMENT: return calo_pkg::NS_EXT;
			calo_pkg::OP_RLD, calo_pkg::OP_RRD: return calo_pkg::NS_ROT;
			default: return calo_pkg::NS_BYTE;
		endcase
	endfunction

	// Decode of the offered instruction
	assign dop = dec(op_byte0, op_byte1);
	assign dsel = (dop == calo_pkg::OP_INR || dop == calo_pkg::OP_DCR) ? op_byte0[1:0] :
		(dop == calo_pkg::OP_INX || dop == calo_pkg::OP_DCX) ? op_byte0[5:4] : op_byte1[1:0];
	assign acc = op_valid && s_r.rdy && s_r.st == calo_pkg::ST_IDLE;
	assign wal = {s_r.awa[ADDR_W-1:2], 2'b00};
	assign ral = {s_axi_araddr[ADDR_W-1:2], 2'b00};
	assign ea_lo = s_r.ea[7:0];

	// Next-state logic: bus slave, then instruction engine
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		wtmp = 32'h00000000;
		bres = 8'h00;
		pres = 16'h0000;
		bwr = 1'b0;
		pwr = 1'b0;
		// Selected byte register
		case (s_r.sel)
			2'd1: bval = s_r.a;
			2'd2: bval = s_r.b;
			2'd3: bval = s_r.c;
			default: bval = 8'h00;
		endcase
		// Selected pair, zero meaning SP
		case (s_r.sel)
			2'd1: pval = s_r.bc;
			2'd2: pval = s_r.de;
			2'd3: pval = s_r.hl;
			default: pval = s_r.sp;
		endcase
		and16 = s_r.ea & pval;
		rem16 = (bval == 8'h00) ? 16'h0000 : s_r.ea % {8'h00, bval};
		// Step operand: memory byte for page ops
		xin = (s_r.op == calo_pkg::OP_PAGE_INCREMENT || s_r.op == calo_pkg::OP_PAGE_DECREMENT) ? s_r.mdat : bval;
		xres = (s_r.op == calo_pkg::OP_INR || s_r.op == calo_pkg::OP_PAGE_INCREMENT) ? xin + 8'h01 : xin - 8'h01;
		// Decimal adjust decision
		lo_adj = s_r.hc || s_r.a[3:0] >= 4'ha;
		hi_adj = s_r.cy || s_r.a[7:4] >= 4'ha || (s_r.a[3:0] >= 4'ha && !s_r.hc && s_r.a[7:4] >= 4'h9);
		sum9 = {1'b0, s_r.a} + {1'b0, hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
		// Write address and data capture
		if (s_axi_awvalid && s_r.awr) begin
			s_nxt.awg = 1'b1;
			s_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wr) begin
			s_nxt.wg = 1'b1;
			s_nxt.wd = s_axi_wdata;
			s_nxt.ws = s_axi_wstrb;
		end
		if (s_r.bv && s_axi_bready) begin
			s_nxt.bv = 1'b0;
		end
		// Perform the write once both halves are held
		if (s_r.awg && s_r.wg && !s_r.bv) begin
			s_nxt.awg = 1'b0;
			s_nxt.wg = 1'b0;
			s_nxt.bv = 1'b1;
			s_nxt.br = calo_pkg::RESP_OK;
			case (wal)
				ADDR_W'(calo_pkg::OFF_BYTES): begin
					wtmp = wmerge({s_r.v, s_r.c, s_r.b, s_r.a}, s_r.wd, s_r.ws);
					{s_nxt.v, s_nxt.c, s_nxt.b, s_nxt.a} = wtmp;
				end
				ADDR_W'(calo_pkg::OFF_EA): begin
					wtmp = wmerge({16'h0000, s_r.ea}, s_r.wd, s_r.ws);
					s_nxt.ea = wtmp[15:0];
				end
				ADDR_W'(calo_pkg::OFF_BC): begin
					wtmp = wmerge({16'h0000, s_r.bc}, s_r.wd, s_r.ws);
					s_nxt.bc = wtmp[15:0];
				end
				ADDR_W'(calo_pkg::OFF_DE): begin
					wtmp = wmerge({16'h0000, s_r.de}, s_r.wd, s_r.ws);
					s_nxt.de = wtmp[15:0];
				end
				ADDR_W'(calo_pkg::OFF_HL): begin
					wtmp = wmerge({16'h0000, s_r.hl}, s_r.wd, s_r.ws);
					s_nxt.hl = wtmp[15:0];
				end
				ADDR_W'(calo_pkg::OFF_SP): begin
					wtmp = wmerge({16'h0000, s_r.sp}, s_r.wd, s_r.ws);
					s_nxt.sp = wtmp[15:0];
				end
				ADDR_W'(calo_pkg::OFF_FLAGS): begin
					wtmp = wmerge({26'h0, s_r.l1, s_r.l0, s_r.sk, s_r.z, s_r.hc, s_r.cy}, s_r.wd, s_r.ws);
					{s_nxt.l1, s_nxt.l0, s_nxt.sk, s_nxt.z, s_nxt.hc, s_nxt.cy} = wtmp[5:0];
				end
				ADDR_W'(calo_pkg::OFF_STAT): s_nxt.br = calo_pkg::RESP_OK; // Read-only, write ignored
				default: s_nxt.br = calo_pkg::RESP_ERR; // Unmapped
			endcase
		end
		// Read channel
		if (s_r.rv && s_axi_rready) begin
			s_nxt.rv = 1'b0;
		end
		if (s_axi_arvalid && s_r.arr) begin
			s_nxt.rv = 1'b1;
			s_nxt.rr = calo_pkg::RESP_OK;
			case (ral)
				ADDR_W'(calo_pkg::OFF_BYTES): s_nxt.rd = {s_r.v, s_r.c, s_r.b, s_r.a};
				ADDR_W'(calo_pkg::OFF_EA): s_nxt.rd = {16'h0000, s_r.ea};
				ADDR_W'(calo_pkg::OFF_BC): s_nxt.rd = {16'h0000, s_r.bc};
				ADDR_W'(calo_pkg::OFF_DE): s_nxt.rd = {16'h0000, s_r.de};
				ADDR_W'(calo_pkg::OFF_HL): s_nxt.rd = {16'h0000, s_r.hl};
				ADDR_W'(calo_pkg::OFF_SP): s_nxt.rd = {16'h0000, s_r.sp};
				ADDR_W'(calo_pkg::OFF_FLAGS): s_nxt.rd = {26'h0, s_r.l1, s_r.l0, s_r.sk, s_r.z, s_r.hc, s_r.cy};
				ADDR_W'(calo_pkg::OFF_STAT): s_nxt.rd = {31'h0, s_r.st == calo_pkg::ST_BUSY};
				default: begin
					s_nxt.rd = 32'h00000000;
					s_nxt.rr = calo_pkg::RESP_ERR;
				end
			endcase
		end
		// Instruction engine
		case (s_r.st)
			calo_pkg::ST_IDLE: begin
				if (acc) begin
					if (s_r.sk || dop == calo_pkg::OP_NONE) begin
						// Fetched but without effect, done next cycle
						s_nxt.sk = 1'b0;
						s_nxt.done = 1'b1;
					end else begin
						s_nxt.st = calo_pkg::ST_BUSY;
						s_nxt.rdy = 1'b0;
						s_nxt.op = dop;
						s_nxt.sel = dsel;
						s_nxt.cnt = nstates(dop) - 6'h01;
						s_nxt.mph = calo_pkg::MP_DN;
						if (dop == calo_pkg::OP_PAGE_INCREMENT || dop == calo_pkg::OP_PAGE_DECREMENT) begin
							s_nxt.mreq = 1'b1;
							s_nxt.mwe = 1'b0;
							s_nxt.maddr = {s_r.v, op_byte1};
							s_nxt.mph = calo_pkg::MP_RD;
						end
						if (dop == calo_pkg::OP_RLD || dop == calo_pkg::OP_RRD) begin
							s_nxt.mreq = 1'b1;
							s_nxt.mwe = 1'b0;
							s_nxt.maddr = s_r.hl;
							s_nxt.mph = calo_pkg::MP_RD;
						end
					end
				end
			end
			calo_pkg::ST_BUSY: begin
				if (s_r.cnt > 6'h01) begin
					s_nxt.cnt = s_r.cnt - 6'h01;
				end
				// Read-modify-write of the memory byte
				if (s_r.mph == calo_pkg::MP_RD && mem_ack) begin
					s_nxt.mdat = mem_rdata;
					s_nxt.mwe = 1'b1;
					s_nxt.mph = calo_pkg::MP_WR;
					case (s_r.op)
						calo_pkg::OP_PAGE_INCREMENT: s_nxt.mwd = mem_rdata + 8'h01;
						calo_pkg::OP_PAGE_DECREMENT: s_nxt.mwd = mem_rdata - 8'h01;
						calo_pkg::OP_RLD: s_nxt.mwd = {mem_rdata[3:0], s_r.a[3:0]};
						default: s_nxt.mwd = {s_r.a[3:0], mem_rdata[7:4]};
					endcase
				end
				if (s_r.mph == calo_pkg::MP_WR && mem_ack) begin
					s_nxt.mreq = 1'b0;
					s_nxt.mwe = 1'b0;
					s_nxt.mph = calo_pkg::MP_DN;
				end
				// Commit in the last state
				if (s_r.cnt == 6'h01 && s_r.mph == calo_pkg::MP_DN) begin
					s_nxt.st = calo_pkg::ST_IDLE;
					s_nxt.rdy = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.sk = 1'b0;
					s_nxt.l1 = 1'b0;
					s_nxt.l0 = 1'b0;
					case (s_r.op)
						calo_pkg::OP_ANDNZ: begin
							s_nxt.z = and16 == 16'h0000;
							s_nxt.sk = and16 != 16'h0000;
						end
						calo_pkg::OP_ANDZ: s_nxt.sk = and16 == 16'h0000;
						calo_pkg::OP_MUL: s_nxt.ea = {8'h00, s_r.a} * {8'h00, bval};
						calo_pkg::OP_DIV: begin
							bwr = 1'b1;
							if (bval == 8'h00) begin
								s_nxt.ea = 16'hffff;
								bres = s_r.ea[7:0];
							end else begin
								s_nxt.ea = s_r.ea / {8'h00, bval};
								bres = rem16[7:0];
							end
						end
						calo_pkg::OP_INR, calo_pkg::OP_DCR, calo_pkg::OP_PAGE_INCREMENT, calo_pkg::OP_PAGE_DECREMENT: begin
							bwr = (s_r.op == calo_pkg::OP_INR || s_r.op == calo_pkg::OP_DCR);
							bres = xres;
							s_nxt.z = xres == 8'h00;
							if (s_r.op == calo_pkg::OP_INR || s_r.op == calo_pkg::OP_PAGE_INCREMENT) begin
								s_nxt.sk = xin == 8'hff;
								s_nxt.hc = xin[3:0] == 4'hf;
							end else begin
								s_nxt.sk = xin == 8'h00;
								s_nxt.hc = xin[3:0] == 4'h0;
							end
						end
						calo_pkg::OP_INX: begin
							pwr = 1'b1;
							pres = pval + 16'h0001;
						end
						calo_pkg::OP_DCX: begin
							pwr = 1'b1;
							pres = pval - 16'h0001;
						end
						calo_pkg::OP_INXEA: s_nxt.ea = s_r.ea + 16'h0001;
						calo_pkg::OP_DCXEA: s_nxt.ea = s_r.ea - 16'h0001;
						calo_pkg::OP_DAA: begin
							s_nxt.a = sum9[7:0];
							s_nxt.z = sum9[7:0] == 8'h00;
							s_nxt.cy = hi_adj;
							s_nxt.hc = ({1'b0, s_r.a[3:0]} + {2'b00, lo_adj, lo_adj, 1'b0}) > 5'h0f;
						end
						calo_pkg::OP_STC: s_nxt.cy = 1'b1;
						calo_pkg::OP_CLC: s_nxt.cy = 1'b0;
						calo_pkg::OP_ACCUMULATOR_TWOS_COMPLEMENT: s_nxt.a = ~s_r.a + 8'h01;
						calo_pkg::OP_RLD: s_nxt.a = {s_r.a[7:4], s_r.mdat[7:4]};
						calo_pkg::OP_RRD: s_nxt.a = {s_r.a[7:4], s_r.mdat[3:0]};
						default: s_nxt.sk = 1'b0;
					endcase
					// Write-back of the selected byte register
					if (bwr) begin
						case (s_r.sel)
							2'd1: s_nxt.a = bres;
							2'd2: s_nxt.b = bres;
							2'd3: s_nxt.c = bres;
							default: s_nxt.a = s_r.a;
						endcase
					end
					// Write-back of the selected pair
					if (pwr) begin
						case (s_r.sel)
							2'd1: s_nxt.bc = pres;
							2'd2: s_nxt.de = pres;
							2'd3: s_nxt.hl = pres;
							default: s_nxt.sp = pres;
						endcase
					end
				end
			end
			default: s_nxt.st = calo_pkg::ST_IDLE;
		endcase
		// Bus readies follow the held state
		s_nxt.awr = !s_nxt.awg;
		s_nxt.wr = !s_nxt.wg;
		s_nxt.arr = !s_nxt.rv;
		// Instruction port ready whenever the engine is idle; low in reset, set one clock after it
		s_nxt.rdy = s_nxt.st == calo_pkg::ST_IDLE;
	end

	// State register, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.ea <= calo_pkg::RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign s_axi_awready = s_r.awr;
	assign s_axi_wready = s_r.wr;
	assign s_axi_bresp = s_r.br;
	assign s_axi_bvalid = s_r.bv;
	assign s_axi_arready = s_r.arr;
	assign s_axi_rdata = s_r.rd;
	assign s_axi_rresp = s_r.rr;
	assign s_axi_rvalid = s_r.rv;
	assign op_ready = s_r.rdy;
	assign op_done = s_r.done;
	assign pass_over = s_r.sk;
	assign mem_req = s_r.mreq;
	assign mem_we = s_r.mwe;
	assign mem_addr = s_r.maddr;
	assign mem_wdata = s_r.mwd;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_skip_drop: assert property (acc && s_r.sk |=> op_done && !s_r.sk && $stable(s_r.a) && $stable(s_r.ea))
		else $error("skipped instruction had an effect");
	chk_inr_value: assert property (acc && !s_r.sk && dop == calo_pkg::OP_INR && dsel == 2'd1 |-> ##4
		op_done && s_r.a == $past(s_r.a, 4) + 8'h01 && s_r.sk == ($past(s_r.a, 4) == 8'hff))
		else $error("byte increment wrong");
	chk_dcr_borrow: assert property (acc && !s_r.sk && dop == calo_pkg::OP_DCR && dsel == 2'd1 |-> ##4
		op_done && s_r.sk == ($past(s_r.a, 4) == 8'h00))
		else $error("byte decrement skip wrong");
	chk_dcr_carry: assert property (acc && !s_r.sk && dop == calo_pkg::OP_DCR |-> ##4
		s_r.cy == $past(s_r.cy, 4) && !s_r.l1 && !s_r.l0)
		else $error("step op touched carry or chain flags");
	chk_mul_prod: assert property (acc && !s_r.sk && dop == calo_pkg::OP_MUL && dsel == 2'd2 |-> ##32
		op_done && s_r.ea == {8'h00, $past(s_r.a, 32)} * {8'h00, $past(s_r.b, 32)})
		else $error("product wrong or late");
	chk_div_zero: assert property (acc && !s_r.sk && dop == calo_pkg::OP_DIV && dsel == 2'd3 && s_r.c == 8'h00
		|-> ##59 op_done && s_r.ea == 16'hffff && s_r.c == $past(ea_lo, 59))
		else $error("zero divisor result wrong");
	chk_stc_cy: assert property (acc && !s_r.sk && dop == calo_pkg::OP_STC |-> ##8
		op_done && s_r.cy && !s_r.sk && !s_r.l1)
		else $error("carry set wrong");
	chk_accumulator_twos_complement_val: assert property (acc && !s_r.sk && dop == calo_pkg::OP_ACCUMULATOR_TWOS_COMPLEMENT |-> ##8
		op_done && s_r.a == ~$past(s_r.a, 8) + 8'h01)
		else $error("negate wrong");
	chk_pair_step: assert property (acc && !s_r.sk && dop == calo_pkg::OP_INX |-> ##7 op_done && !s_r.sk)
		else $error("pair increment late or skipped");
	chk_andz_skip: assert property (acc && !s_r.sk && dop == calo_pkg::OP_ANDZ && dsel == 2'd1 |-> ##11
		op_done && s_r.ea == $past(s_r.ea, 11) && s_r.sk == (($past(s_r.ea, 11) & $past(s_r.bc, 11)) == 16'h0000))
		else $error("zero test wrong");
	chk_ea_inc: assert property (acc && !s_r.sk && dop == calo_pkg::OP_INXEA |-> ##7
		op_done && s_r.ea == $past(s_r.ea, 7) + 16'h0001)
		else $error("wide increment wrong");
endmodule

// >>> calo_mem_model.sv
// Working memory model answering the datapath's byte accesses
`timescale 1ns/100ps
module calo_mem_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] mem [0:65535]; // Byte store
	logic [1:0] wait_r; // Wait states spent
	initial mem_rdata = 8'h00;
	initial mem_ack = 1'b0;
	// One ack per access; read data toggles in every cycle that does not answer a read
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!aresetn) begin
			wait_r <= 2'h0;
		end else if (mem_req && !mem_ack) begin
			if (wait_r == (slow ? 2'h3 : 2'h0)) begin
				mem_ack <= 1'b1;
				wait_r <= 2'h0;
				if (mem_we) mem[mem_addr] <= mem_wdata;
				else mem_rdata <= mem[mem_addr];
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule

// >>> tb_top.sv
// Self-checking bench for the arithmetic/logic datapath
`timescale 1ns/100ps
module tb_top;
	logic aclk = 0, aresetn = 0, slow = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, op_byte0 = 0, op_byte1 = 0, mem_wdata, mem_rdata;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_valid = 0;
	logic op_ready, op_done, pass_over, mem_req, mem_we, mem_ack;
	logic [15:0] mem_addr;
	int miscompares = 0, comparisons = 0, cycles = 0;
	calo_datapath uut (.*);
	calo_mem_model mdl (.*);
	always #4 aclk = ~aclk;
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask
	// Register write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, calo_pkg::RESP_OK);
	endtask
	// Register read compared with an expectation
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask
	// One instruction; n states expected, skip flag after it
	task automatic op(input logic [7:0] b0, input logic [7:0] b1, input int n, input logic sk);
		int c;
		@(posedge aclk);
		op_byte0 <= b0;
		op_byte1 <= b1;
		op_valid <= 1;
		do @(posedge aclk); while (!op_ready);
		op_valid <= 0;
		c = 0;
		do begin
			@(posedge aclk);
			c++;
		end while (!op_done);
		if (n > 0) chk(32'(c), 32'(n));
		chk(pass_over, sk);
	endtask
	// Verdict
	task automatic end_of_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test;
		end
	end
	// Byte steps, skip and suppression
	task automatic t_step;
		wr(8'h18, 32'h31);
		wr(8'h00, 32'h12000bff);
		op(8'h41, 8'h00, 4, 1);
		rc(8'h00, 32'h12000b00, 2'h0);
		rc(8'h18, 32'h0f, 2'h0);
		op(8'h41, 8'h00, 1, 0);
		rc(8'h00, 32'h12000b00, 2'h0);
		op(8'h53, 8'h00, 4, 1);
		rc(8'h00, 32'h12ff0b00, 2'h0);
		op(8'h41, 8'h00, 1, 0);
		$display("step test done");
	endtask
	// Multiply, divide by zero and by B
	task automatic t_muldiv;
		wr(8'h00, 32'h12000b0c);
		op(8'h48, {calo_pkg::OPC_MUL, 2'b10}, 32, 0);
		rc(8'h04, 32'h84, 2'h0);
		wr(8'h04, 32'h1234);
		op(8'h48, {calo_pkg::OPC_DIV, 2'b11}, 59, 0);
		rc(8'h04, 32'hffff, 2'h0);
		rc(8'h00, 32'h12340b0c, 2'h0);
		op(8'h48, {calo_pkg::OPC_DIV, 2'b10}, 59, 0);
		rc(8'h04, 32'h1745, 2'h0);
		rc(8'h00, 32'h1234080c, 2'h0);
		$display("muldiv test done");
	endtask
	// Page-addressed steps, prompt and slow memory
	task automatic t_page;
		mdl.mem[16'h12a5] = 8'hff;
		op(8'h20, 8'ha5, 16, 1);
		chk(mdl.mem[16'h12a5], 8'h00);
		slow <= 1;
		op(8'h30, 8'ha5, 1, 0);
		op(8'h30, 8'ha5, -1, 1);
		chk(mdl.mem[16'h12a5], 8'hff);
		op(8'h41, 8'h00, 1, 0);
		slow <= 0;
		$display("page test done");
	endtask
	// AND tests, pair steps, digit rotates, carry, negate, adjust
	task automatic t_misc;
		wr(8'h04, 32'h00f0);
		wr(8'h08, 32'h0f00);
		wr(8'h0c, 32'h0010);
		op(8'h74, 8'hdd, 11, 1);
		op(8'h41, 8'h00, 1, 0);
		op(8'h74, 8'hce, 11, 1);
		rc(8'h04, 32'h00f0, 2'h0);
		op(8'h41, 8'h00, 1, 0);
		op(8'h12, 8'h00, 7, 0);
		rc(8'h08, 32'h0f01, 2'h0);
		op(calo_pkg::OPC_DCXEA, 8'h00, 7, 0);
		rc(8'h04, 32'h00ef, 2'h0);
		op(calo_pkg::OPC_INXEA, 8'h00, 7, 0);
		rc(8'h04, 32'h00f0, 2'h0);
		wr(8'h10, 32'h12a5);
		wr(8'h00, 32'ha3);
		mdl.mem[16'h12a5] = 8'h5c;
		op(8'h48, 8'h38, 17, 0);
		chk(mdl.mem[16'h12a5], 8'hc3);
		rc(8'h00, 32'ha5, 2'h0);
		op(8'h48, 8'h39, 17, 0);
		chk(mdl.mem[16'h12a5], 8'h5c);
		wr(8'h00, 32'h01);
		wr(8'h18, 32'h03);
		op(8'h61, 8'h00, -1, 0);
		rc(8'h00, 32'h67, 2'h0);
		op(8'h48, 8'h3a, 8, 0);
		rc(8'h00, 32'h99, 2'h0);
		op(8'h48, 8'h2a, 8, 0);
		rc(8'h18, 32'h00, 2'h0);
		op(8'h48, 8'h2b, 8, 0);
		rc(8'h18, 32'h01, 2'h0);
		rc(8'h20, 32'h0, calo_pkg::RESP_ERR);
		$display("misc test done");
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		t_step;
		t_muldiv;
		t_page;
		t_misc;
		end_of_test;
	end
endmodule
